//--- lacb_exec.sv
// Purpose: Execute slice for AND literal, AND file, add-carry, branch-carry
// Assumes: Memory returns read data in the cycle after the read strobe
// Notes: One instruction per four phases; taken branch flushes one cycle
// Notes on behaviour
// - AND literal into accumulator, flags N Z
// - AND accumulator with file, flags N Z
// - Destination bit 0 writes accumulator only
// - Destination bit 1 writes file register back
// - Access bit picks access bank or bank pointer
// - Extended set, access, low address: indexed offset
// - Carry set: pc becomes pc plus 2 plus 2n
// - Taken branch two cycles, else one
// - Add with carry updates N OV C DC Z
`timescale 1ns/100ps
module lacb_exec
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [lacb_pkg::INSTR_W-1:0] instr_in,
	input wire logic ext_set_en_in,
	input wire logic [lacb_pkg::BANK_W-1:0] bank_select_pointer_in,
	input wire logic [lacb_pkg::ADDR_W-1:0] index_base_in,
	input wire logic [lacb_pkg::DATA_W-1:0] file_rd_data_in,
	input wire logic preset_en_in,
	input wire logic [lacb_pkg::DATA_W-1:0] preset_acc_in,
	input wire logic preset_carry_in,
	output lacb_pkg::lacb_phase_type phase_out,
	output logic [lacb_pkg::ADDR_W-1:0] file_addr_out,
	output logic file_rd_en_out,
	output logic file_wr_en_out,
	output logic [lacb_pkg::DATA_W-1:0] file_wr_data_out,
	output logic [lacb_pkg::DATA_W-1:0] acc_out,
	output logic [lacb_pkg::STATUS_W-1:0] status_out,
	output logic [lacb_pkg::PC_W-1:0] pc_out,
	output logic flush_out
);
	import lacb_pkg::*;

	function automatic lacb_op_type decode_op(input logic [INSTR_W-1:0] ins);
		if (ins[15:8] == OPC_AND_LIT)
			decode_op = OP_AND_LIT;
		else if (ins[15:10] == OPC_AND_FILE)
			decode_op = OP_AND_FILE;
		else if (ins[15:10] == OPC_ADD_CARRY)
			decode_op = OP_ADD_CARRY;
		else if (ins[15:8] == OPC_BRANCH_CARRY)
			decode_op = OP_BRANCH_CARRY;
		else
			decode_op = OP_NONE;
	endfunction

	function automatic logic uses_file(input lacb_op_type op);
		uses_file = (op == OP_AND_FILE) || (op == OP_ADD_CARRY);
	endfunction

	lacb_phase_type phase_reg, phase_next;
	lacb_op_type op_reg, op_next;
	logic [INSTR_W-1:0] instr_reg, instr_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] operand_reg, operand_next;
	logic [DATA_W-1:0] result_reg, result_next;
	logic [STATUS_W-1:0] flags_reg, flags_next;
	logic [DATA_W-1:0] acc_reg, acc_next;
	logic [STATUS_W-1:0] status_reg, status_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic flush_reg, flush_next;
	logic indexed_reg, indexed_next;
	logic [DATA_W-1:0] alu_result;
	logic [DATA_W-1:0] alu_b;
	logic alu_c, alu_dc, alu_ov, alu_n, alu_z;
	lacb_alu_type alu_op;
	logic [7:0] fld;
	logic dest_file;
	logic taken;

	assign fld = instr_reg[7:0];
	assign dest_file = instr_reg[DEST_BIT];
	assign taken = (op_reg == OP_BRANCH_CARRY) && status_reg[FLAG_C];
	assign alu_op = (op_reg == OP_ADD_CARRY) ? ALU_ADDC : ALU_AND;
	// Literal form reads its operand from the opcode itself; the result
	// is registered at Q3 so the Q4 write data comes from a flip-flop
	assign alu_b = (phase_reg == PH_Q3) ?
		(uses_file(op_reg) ? file_rd_data_in : fld) : operand_reg;

	lacb_alu u_alu
	(
		.op_in(alu_op),
		.a_in(acc_reg),
		.b_in(alu_b),
		.carry_in(status_reg[FLAG_C]),
		.result_out(alu_result),
		.carry_out(alu_c),
		.digit_out(alu_dc),
		.ovf_out(alu_ov),
		.neg_out(alu_n),
		.zero_out(alu_z)
	);

	always_comb
	begin
		phase_next = phase_reg;
		op_next = op_reg;
		instr_next = instr_reg;
		addr_next = addr_reg;
		indexed_next = indexed_reg;
		operand_next = operand_reg;
		result_next = result_reg;
		flags_next = flags_reg;
		acc_next = acc_reg;
		status_next = status_reg;
		pc_next = pc_reg;
		flush_next = flush_reg;
		unique case (phase_reg)
			PH_Q1:
			begin
				phase_next = PH_Q2;
				// A flushed cycle runs as a no-operation
				instr_next = flush_reg ? INSTR_RESET : instr_in;
				op_next = flush_reg ? OP_NONE : decode_op(instr_in);
				indexed_next = 1'b0;
				// Gated opcode sends a flushed cycle's address to 12'h000, or to index_base_in when ext_set_en_in is high
				if (instr_next[ACCESS_BIT])
					addr_next = {bank_select_pointer_in,
						instr_next[7:0]};
				else if (ext_set_en_in && instr_next[7:0] <= ACCESS_LIMIT)
				begin
					addr_next = index_base_in +
						{4'h0, instr_next[7:0]};
					indexed_next = 1'b1;
				end
				else if (instr_next[7:0] <= ACCESS_LIMIT)
					addr_next = {ACCESS_LOW_BANK, instr_next[7:0]};
				else
					addr_next = {ACCESS_HIGH_BANK, instr_next[7:0]};
			end
			PH_Q2:
			begin
				phase_next = PH_Q3;
			end
			PH_Q3:
			begin
				phase_next = PH_Q4;
				operand_next = alu_b;
			end
			PH_Q4:
			begin
				phase_next = PH_Q1;
				flush_next = taken;
				if (flush_reg)
					pc_next = pc_reg;
				else if (taken)
					pc_next = pc_reg + PC_STEP +
						{{12{fld[7]}}, fld, 1'b0};
				else
					pc_next = pc_reg + PC_STEP;
			end
		endcase
		// Result is formed at the process phase from the live read data or the literal
		if (phase_reg == PH_Q4 && op_reg != OP_NONE &&
			op_reg != OP_BRANCH_CARRY)
		begin
			status_next[FLAG_N] = flags_reg[FLAG_N];
			status_next[FLAG_Z] = flags_reg[FLAG_Z];
			if (op_reg == OP_ADD_CARRY)
			begin
				status_next[FLAG_C] = flags_reg[FLAG_C];
				status_next[FLAG_DC] = flags_reg[FLAG_DC];
				status_next[FLAG_OV] = flags_reg[FLAG_OV];
			end
			if (op_reg == OP_AND_LIT || !dest_file)
				acc_next = result_reg;
		end
		result_next = alu_result;
		flags_next = {alu_n, alu_ov, alu_z, alu_dc, alu_c};
		if (preset_en_in)
		begin
			acc_next = preset_acc_in;
			status_next[FLAG_C] = preset_carry_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			phase_reg <= PH_Q1;
			op_reg <= OP_NONE;
			instr_reg <= INSTR_RESET;
			addr_reg <= ADDR_RESET;
			indexed_reg <= 1'b0;
			operand_reg <= ACC_RESET;
			result_reg <= ACC_RESET;
			flags_reg <= STATUS_RESET;
			acc_reg <= ACC_RESET;
			status_reg <= STATUS_RESET;
			pc_reg <= PC_RESET;
			flush_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			phase_reg <= phase_next;
			op_reg <= op_next;
			instr_reg <= instr_next;
			addr_reg <= addr_next;
			indexed_reg <= indexed_next;
			operand_reg <= operand_next;
			result_reg <= result_next;
			flags_reg <= flags_next;
			acc_reg <= acc_next;
			status_reg <= status_next;
			pc_reg <= pc_next;
			flush_reg <= flush_next;
		end
	end

	assign phase_out = phase_reg;
	assign file_addr_out = addr_reg;
	assign file_rd_en_out = (phase_reg == PH_Q2) && uses_file(op_reg);
	// Write strobe only for the file destination
	assign file_wr_en_out = (phase_reg == PH_Q4) && uses_file(op_reg) &&
		dest_file;
	assign file_wr_data_out = result_reg;
	assign acc_out = acc_reg;
	assign status_out = status_reg;
	assign pc_out = pc_reg;
	assign flush_out = flush_reg;

	// Result and flag checks assume preset is idle while the checked instruction runs
	and_lit_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && op_reg == OP_AND_LIT && ce_in &&
		!preset_en_in |=> acc_reg == ($past(acc_reg) & $past(fld)))
		else $error("literal AND result wrong");
	and_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && (op_reg == OP_AND_FILE || op_reg == OP_AND_LIT)
		&& ce_in && !preset_en_in |=>
		status_reg[FLAG_C] == $past(status_reg[FLAG_C]) &&
		status_reg[FLAG_OV] == $past(status_reg[FLAG_OV]) &&
		status_reg[FLAG_DC] == $past(status_reg[FLAG_DC]) &&
		status_reg[FLAG_Z] == ($past(result_reg) == 8'h00))
		else $error("AND touched wrong flags");
	dest_acc_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && op_reg == OP_AND_FILE && ce_in &&
		!preset_en_in && !dest_file |-> !file_wr_en_out ##1
		acc_reg == $past(result_reg))
		else $error("accumulator destination wrong");
	dest_file_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && op_reg == OP_AND_FILE && ce_in &&
		!preset_en_in && dest_file |-> file_wr_en_out &&
		file_wr_data_out == (acc_reg & operand_reg) ##1
		acc_reg == $past(acc_reg))
		else $error("file destination wrong");
	access_bank_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q2 && !instr_reg[ACCESS_BIT] && !indexed_reg |->
		file_addr_out == {(fld > ACCESS_LIMIT) ? ACCESS_HIGH_BANK :
		ACCESS_LOW_BANK, fld})
		else $error("access bank address wrong");
	indexed_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q1 && ce_in && !flush_reg &&
		!instr_in[ACCESS_BIT] &&
		ext_set_en_in && instr_in[7:0] <= ACCESS_LIMIT |=>
		file_addr_out == $past(index_base_in) + {4'h0, $past(instr_in[7:0])})
		else $error("indexed address wrong");
	branch_pc_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && taken && ce_in |=> pc_reg == $past(pc_reg) +
		PC_STEP + {{12{$past(fld[7])}}, $past(fld), 1'b0})
		else $error("branch target wrong");
	branch_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && op_reg == OP_BRANCH_CARRY && ce_in |=>
		flush_reg == $past(status_reg[FLAG_C]) && op_reg == $past(op_reg))
		else $error("branch cycle count wrong");
	add_carry_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && op_reg == OP_ADD_CARRY && ce_in &&
		!preset_en_in |=> status_reg == $past(flags_next))
		else $error("add-with-carry flags wrong");
	phase_seq_a: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q1 && ce_in ##1 ce_in [*3] |=> phase_reg == PH_Q1)
		else $error("phase sequence wrong");

	taken_c: cover property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q4 && taken && ce_in);
	file_wr_c: cover property (@(posedge clk_in) disable iff (rst_in)
		file_wr_en_out && ce_in);
	indexed_c: cover property (@(posedge clk_in) disable iff (rst_in)
		phase_reg == PH_Q2 && indexed_reg && file_rd_en_out);

endmodule // lacb_exec

//--- lacb_pkg.sv
// Purpose: Shared constants and types for the logic and carry-branch slice
// Assumes: Single instruction clock split into four phases
// Notes: Opcode patterns, flag positions and address split live here
package lacb_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	localparam int PC_W = 21;
	localparam int INSTR_W = 16;
	localparam int STATUS_W = 5;

	// Opcode fields
	localparam logic [7:0] OPC_AND_LIT = 8'h0b;
	localparam logic [5:0] OPC_AND_FILE = 6'h05;
	localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
	localparam logic [7:0] OPC_BRANCH_CARRY = 8'he2;
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;

	// Access bank split and bank numbers
	localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

	// Status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;

	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} lacb_phase_type;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_AND_LIT,
		OP_AND_FILE,
		OP_ADD_CARRY,
		OP_BRANCH_CARRY
	} lacb_op_type;

	typedef enum logic {ALU_AND, ALU_ADDC} lacb_alu_type;

endpackage

//--- lacb_alu.sv
// Purpose: Byte ALU for AND and add-with-carry with flag outputs
// Assumes: Purely combinational, caller registers results
// Notes: Carry flags are meaningful only for the add operation
`timescale 1ns/100ps
module lacb_alu
(
	input wire lacb_pkg::lacb_alu_type op_in,
	input wire logic [lacb_pkg::DATA_W-1:0] a_in,
	input wire logic [lacb_pkg::DATA_W-1:0] b_in,
	input wire logic carry_in,
	output logic [lacb_pkg::DATA_W-1:0] result_out,
	output logic carry_out,
	output logic digit_out,
	output logic ovf_out,
	output logic neg_out,
	output logic zero_out
);
	import lacb_pkg::*;

	logic [DATA_W:0] sum;
	logic [4:0] nib;

	always_comb
	begin
		sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
		nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
		carry_out = sum[DATA_W];
		digit_out = nib[4];
		// Overflow when like-signed operands give an unlike sign
		ovf_out = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]);
		if (op_in == ALU_AND)
			result_out = a_in & b_in;
		else
			result_out = sum[DATA_W-1:0];
		neg_out = result_out[DATA_W-1];
		zero_out = (result_out == 8'h00);
	end

endmodule // lacb_alu

//--- lacb_exec_test.sv
// Purpose: Self-checking bench for the logic and carry-branch slice
// Assumes: ce_in held high; one instruction every four enabled cycles
// Notes: Fixed-seed xorshift stimulus with directed corner cases first
`timescale 1ns/100ps
module lacb_exec_test;
	import lacb_pkg::*;

	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [INSTR_W-1:0] instr_in = 16'h0000;
	logic ext_set_en_in = 1'b0;
	logic [BANK_W-1:0] bank_select_pointer_in = 4'h0;
	logic [ADDR_W-1:0] index_base_in = 12'h000;
	logic [DATA_W-1:0] file_rd_data_in = 8'h00;
	logic preset_en_in = 1'b0;
	logic [DATA_W-1:0] preset_acc_in = 8'h00;
	logic preset_carry_in = 1'b0;
	lacb_phase_type phase_out;
	logic [ADDR_W-1:0] file_addr_out;
	logic file_rd_en_out;
	logic file_wr_en_out;
	logic [DATA_W-1:0] file_wr_data_out;
	logic [DATA_W-1:0] acc_out;
	logic [STATUS_W-1:0] status_out;
	logic [PC_W-1:0] pc_out;
	logic flush_out;
	logic [7:0] m_acc = 8'h00;
	logic [4:0] m_st = 5'h00;
	logic [20:0] m_pc = 21'h000000;
	logic m_flush = 1'b0;
	logic [31:0] seed = 32'hbbb6;
	logic [31:0] v;
	int error_cnt = 0;
	int n_checks = 0;
	int cycles = 0;

	lacb_exec uut
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.instr_in(instr_in),
		.ext_set_en_in(ext_set_en_in),
		.bank_select_pointer_in(bank_select_pointer_in),
		.index_base_in(index_base_in),
		.file_rd_data_in(file_rd_data_in),
		.preset_en_in(preset_en_in),
		.preset_acc_in(preset_acc_in),
		.preset_carry_in(preset_carry_in),
		.phase_out(phase_out),
		.file_addr_out(file_addr_out),
		.file_rd_en_out(file_rd_en_out),
		.file_wr_en_out(file_wr_en_out),
		.file_wr_data_out(file_wr_data_out),
		.acc_out(acc_out),
		.status_out(status_out),
		.pc_out(pc_out),
		.flush_out(flush_out)
	);

	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected address from the operand bits and the side inputs in r
	function automatic logic [11:0] faddr(input logic [15:0] ins,
		input logic [31:0] r);
		if (ins[ACCESS_BIT])
			return {r[4:1], ins[7:0]};
		if (ins[7:0] <= ACCESS_LIMIT)
			return r[0] ? r[16:5] + {4'h0, ins[7:0]}
				: {ACCESS_LOW_BANK, ins[7:0]};
		return {ACCESS_HIGH_BANK, ins[7:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One full instruction cycle, entered at the edge that opens Q1;
	// results of the previous one are checked while this Q1 stands.
	// Preset only on opcodes that leave acc alone
	task automatic run(input logic [15:0] ins, input logic [7:0] mem,
		input logic pe, input logic [7:0] pa, input logic pcy);
		logic isl, isf, isa, isb, wr;
		logic [31:0] r;
		logic [11:0] adr;
		logic [8:0] s;
		logic [4:0] lo;
		logic [7:0] res;
		r = rnd();
		isl = !m_flush && ins[15:8] == OPC_AND_LIT;
		isf = !m_flush && ins[15:10] == OPC_AND_FILE;
		isa = !m_flush && ins[15:10] == OPC_ADD_CARRY;
		isb = !m_flush && ins[15:8] == OPC_BRANCH_CARRY;
		adr = faddr(ins, r);
		ext_set_en_in <= r[0];
		bank_select_pointer_in <= r[4:1];
		index_base_in <= r[16:5];
		instr_in <= ins;
		@(negedge clk_in);
		chk(phase_out, PH_Q1);
		chk(acc_out, m_acc);
		chk(status_out, m_st);
		chk(pc_out, m_pc);
		chk(flush_out, m_flush);
		@(posedge clk_in);
		preset_en_in <= pe;
		preset_acc_in <= pa;
		preset_carry_in <= pcy;
		instr_in <= r[31:16];
		@(negedge clk_in);
		chk(file_rd_en_out, isf | isa);
		if (isf | isa)
			chk(file_addr_out, adr);
		@(posedge clk_in);
		preset_en_in <= 1'b0;
		file_rd_data_in <= mem;
		if (pe)
		begin
			m_acc = pa;
			m_st[FLAG_C] = pcy;
		end
		res = m_acc & (isl ? ins[7:0] : mem);
		s = {1'b0, m_acc} + {1'b0, mem} + {8'h00, m_st[FLAG_C]};
		lo = {1'b0, m_acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, m_st[FLAG_C]};
		if (isa)
		begin
			m_st[FLAG_OV] = (m_acc[7] == mem[7]) && (s[7] != m_acc[7]);
			m_st[FLAG_C] = s[8];
			m_st[FLAG_DC] = lo[4];
			res = s[7:0];
		end
		if (isl | isf | isa)
		begin
			m_st[FLAG_N] = res[7];
			m_st[FLAG_Z] = (res == 8'h00);
			if (isl || !ins[DEST_BIT])
				m_acc = res;
		end
		if (isb && m_st[FLAG_C])
			m_pc = m_pc + 21'h2 + {{12{ins[7]}}, ins[7:0], 1'b0};
		else if (!m_flush)
			m_pc = m_pc + 21'h2;
		m_flush = isb && m_st[FLAG_C];
		wr = (isf | isa) && ins[DEST_BIT];
		@(posedge clk_in);
		// Stale read data must not leak into the write phase
		file_rd_data_in <= ~mem;
		@(negedge clk_in);
		chk(file_wr_en_out, wr);
		if (wr)
			chk(file_wr_data_out, res);
		@(posedge clk_in);
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles > 6000)
		begin
			error_cnt++;
			final_report();
		end
	end

	initial
	begin
		repeat (9) @(posedge clk_in);
		@(negedge clk_in);
		chk(phase_out, PH_Q1);
		chk({acc_out, status_out, flush_out}, 32'h0);
		@(posedge clk_in);
		// Release on a clock edge: the phase counter opens Q1 here
		rst_in <= 1'b0;
		run(16'h0000, 8'h11, 1'b1, 8'ha3, 1'b0);
		run(16'h0b5f, 8'hff, 1'b0, 8'h00, 1'b0);
		run(16'h0000, 8'h00, 1'b1, 8'h17, 1'b0);
		run(16'h145f, 8'hc2, 1'b0, 8'h00, 1'b0);
		run(16'h1660, 8'hf0, 1'b0, 8'h00, 1'b0);
		run(16'h1733, 8'h0f, 1'b0, 8'h00, 1'b0);
		run(16'h0000, 8'h00, 1'b1, 8'h4d, 1'b1);
		run(16'h2102, 8'h02, 1'b0, 8'h00, 1'b0);
		run(16'h0000, 8'h00, 1'b1, 8'h00, 1'b1);
		run(16'he280, 8'h00, 1'b0, 8'h00, 1'b0);
		run(16'h0bff, 8'h00, 1'b0, 8'h00, 1'b0);
		run(16'he27f, 8'h00, 1'b0, 8'h00, 1'b0);
		run(16'h1600, 8'h00, 1'b0, 8'h00, 1'b0);
		run(16'h0000, 8'h00, 1'b1, 8'h00, 1'b0);
		run(16'he205, 8'h00, 1'b0, 8'h00, 1'b0);
		repeat (300)
		begin
			v = rnd();
			case (v[2:0])
				3'd0: run({OPC_AND_LIT, v[15:8]}, v[31:24], 1'b0, 8'h00, 1'b0);
				3'd1, 3'd2: run({OPC_AND_FILE, v[17:8]}, v[31:24], 1'b0,
					8'h00, 1'b0);
				3'd3: run({OPC_ADD_CARRY, v[17:8]}, v[31:24], 1'b0, 8'h00, 1'b0);
				3'd4, 3'd5: run({OPC_BRANCH_CARRY, v[15:8]}, v[31:24], 1'b0,
					8'h00, 1'b0);
				3'd6: run(16'h0000, v[31:24], !m_flush, v[15:8], v[16]);
				default: run(v[31:16], v[15:8], 1'b0, 8'h00, 1'b0);
			endcase
		end
		// Last instruction's results stand through the next Q1
		@(negedge clk_in);
		chk(acc_out, m_acc);
		chk(status_out, m_st);
		chk(pc_out, m_pc);
		chk(flush_out, m_flush);
		final_report();
	end
endmodule // lacb_exec_test
